// File: core/gio_pkg.sv
// Purpose: constants and types shared by the 32-line I/O line controller
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
`default_nettype none
package gio_pkg;

  localparam int          GIO_LINES = 32;
  localparam int          GIO_AW    = 8;
  typedef logic [GIO_LINES-1:0] gio_word_t;
  typedef logic [GIO_AW-1:0]    gio_addr_t;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam gio_addr_t OFS_CTRL_SEL_SET      = 8'h00;
  localparam gio_addr_t OFS_CTRL_SEL_CLEAR    = 8'h04;
  localparam gio_addr_t OFS_CTRL_SEL_STATUS   = 8'h08;
  localparam gio_addr_t OFS_OUT_EN_SET        = 8'h10;
  localparam gio_addr_t OFS_OUT_EN_CLEAR      = 8'h14;
  localparam gio_addr_t OFS_OUT_EN_STATUS     = 8'h18;
  localparam gio_addr_t OFS_FILTER_SET        = 8'h20;
  localparam gio_addr_t OFS_FILTER_CLEAR      = 8'h24;
  localparam gio_addr_t OFS_FILTER_STATUS     = 8'h28;
  localparam gio_addr_t OFS_OUT_DATA_SET      = 8'h30;
  localparam gio_addr_t OFS_OUT_DATA_CLEAR    = 8'h34;
  localparam gio_addr_t OFS_OUT_DATA_VALUE    = 8'h38;
  localparam gio_addr_t OFS_PIN_LEVEL         = 8'h3C;
  localparam gio_addr_t OFS_IRQ_MASK_SET      = 8'h40;
  localparam gio_addr_t OFS_IRQ_MASK_CLEAR    = 8'h44;
  localparam gio_addr_t OFS_IRQ_MASK          = 8'h48;
  localparam gio_addr_t OFS_IRQ_STATUS        = 8'h4C;
  localparam gio_addr_t OFS_OPEN_DRAIN_SET    = 8'h50;
  localparam gio_addr_t OFS_OPEN_DRAIN_CLEAR  = 8'h54;
  localparam gio_addr_t OFS_OPEN_DRAIN_STATUS = 8'h58;
  localparam gio_addr_t OFS_PERIPH_A_SELECT   = 8'h70;
  localparam gio_addr_t OFS_PERIPH_B_SELECT   = 8'h74;
  localparam gio_addr_t OFS_PERIPH_CHOICE     = 8'h78;
  localparam gio_addr_t OFS_WRITE_MASK_SET    = 8'hA0;
  localparam gio_addr_t OFS_WRITE_MASK_CLEAR  = 8'hA4;
  localparam gio_addr_t OFS_WRITE_MASK_STATUS = 8'hA8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  // controller ownership at reset is product specific; all lines owned here
  localparam gio_word_t RST_CTRL_SEL   = 32'hFFFF_FFFF;
  localparam gio_word_t RST_ZERO       = 32'h0000_0000;
  localparam gio_word_t RST_PIN_OE_N   = 32'hFFFF_FFFF;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    gio_word_t outA;
    gio_word_t drvA;
    gio_word_t outB;
    gio_word_t drvB;
  } gio_periph_t;

  typedef struct packed {
    gio_word_t ctrlSel;
    gio_word_t periphChoice;
    gio_word_t outEn;
    gio_word_t outData;
    gio_word_t writeMask;
    gio_word_t openDrain;
    gio_word_t fltEn;
    gio_word_t irqMask;
    gio_word_t irqStat;
    gio_word_t pinSmp;
    gio_word_t pinFlt;
    gio_word_t lvlPrev;
    gio_word_t pinOut;
    gio_word_t pinOeN;
    gio_word_t rdData;
    logic      rdDone;
    logic      rdErr;
  } gio_state_t;

endpackage
`default_nettype wire

// File: core/gio_ctrl.sv
// Purpose: 32-line I/O line controller: output drive, open drain, pin readback,
//          glitch filter and input change detection, reached over APB
// Assumes: pins synchronous to sys_clk; ctrlClkOn models the controller clock gate
// Notes:   one wait-free APB access; read data is captured in the setup cycle
//
// Summary of operation
// - lines given to a peripheral are driven as peripheral A or B decides
// - output enable set and clear writes steer whether the controller drives a line
// - output data set and clear writes steer the driven level
// - enable and data bits update even while a peripheral owns the line
// - direct output data writes change only bits open in the write mask
// - write mask set and clear writes; mask resets to zero
// - open-drain lines are only ever pulled low, never driven high
// - open-drain set and clear writes work for any owner; reset to zero
// - pin level readback shows the real level of every line
// - with the controller clock off, readback holds the last sampled levels
// - enabled filter rejects sub-half-cycle glitches, passes pulses of a cycle
// - enabled filter adds one cycle of latency
// - filter set and clear writes enable the per-line glitch filter
// - filter affects readback and change detection only; peripherals see raw pins
// - change interrupt mask set and clear writes
// - changes found by comparing two successive samples while the clock runs
// - change sets status; interrupt is OR of masked status over all lines
// - reading change status returns pending bits and clears them
// - controller select status reads 1 when the controller owns the line
// - peripheral choice 0 selects A, 1 selects B, output path only
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module gio_ctrl
  import gio_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  input  wire logic        ctrlClkOn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire gio_addr_t   paddr,
  input  wire gio_word_t   pwdata,
  output logic             pready,
  output gio_word_t        prdata,
  output logic             pslverr,
  input  wire gio_word_t   pinIn,
  output gio_word_t        pinOut,
  output gio_word_t        pinOeN,
  input  wire gio_periph_t periph,
  output gio_word_t        periphIn,
  output logic             changeIrq
);

  gio_state_t st_reg;
  gio_state_t st_next;

  logic       setupPh;
  logic       accessDone;
  logic       wrDone;
  logic       rdClear;
  logic       knownAddr;
  gio_word_t  levelNow;
  gio_word_t  changed;
  gio_word_t  rdMux;
  gio_word_t  drvLevel;
  gio_word_t  drvOn;

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // read data is latched at setup so the access phase never waits on logic
  assign setupPh    = psel & ~penable;
  assign pready     = st_reg.rdDone & clkEn;
  assign accessDone = psel & penable & pready;
  assign wrDone     = accessDone & pwrite & ~st_reg.rdErr;
  assign prdata     = st_reg.rdData;
  assign pslverr    = st_reg.rdErr;

  // ****************************************************************
  // input path
  // ****************************************************************
  // filtered level is the sample delayed one more cycle; pins are synchronous,
  // so nothing shorter than a cycle can reach the sampler
  assign levelNow  = (st_reg.fltEn & st_reg.pinFlt) | (~st_reg.fltEn & st_reg.pinSmp);
  assign changed   = ctrlClkOn ? (levelNow ^ st_reg.lvlPrev) : '0;
  assign periphIn  = pinIn;
  assign changeIrq = |(st_reg.irqStat & st_reg.irqMask);

  // ****************************************************************
  // output drive selection
  // ****************************************************************
  always_comb begin
    drvLevel = '0;
    drvOn    = '0;
    for (int i = 0; i < GIO_LINES; i++) begin
      if (st_reg.ctrlSel[i]) begin
        drvLevel[i] = st_reg.outData[i];
        drvOn[i]    = st_reg.outEn[i];
      end else if (st_reg.periphChoice[i]) begin
        drvLevel[i] = periph.outB[i];
        drvOn[i]    = periph.drvB[i];
      end else begin
        drvLevel[i] = periph.outA[i];
        drvOn[i]    = periph.drvA[i];
      end
    end
  end

  // ****************************************************************
  // read decode
  // ****************************************************************
  always_comb begin
    rdMux     = '0;
    knownAddr = 1'b1;
    unique case (paddr)
      OFS_CTRL_SEL_STATUS:   rdMux = st_reg.ctrlSel;
      OFS_OUT_EN_STATUS:     rdMux = st_reg.outEn;
      OFS_FILTER_STATUS:     rdMux = st_reg.fltEn;
      OFS_OUT_DATA_VALUE:    rdMux = st_reg.outData;
      OFS_PIN_LEVEL:         rdMux = levelNow;
      OFS_IRQ_MASK:          rdMux = st_reg.irqMask;
      OFS_IRQ_STATUS:        rdMux = st_reg.irqStat;
      OFS_OPEN_DRAIN_STATUS: rdMux = st_reg.openDrain;
      OFS_PERIPH_CHOICE:     rdMux = st_reg.periphChoice;
      OFS_WRITE_MASK_STATUS: rdMux = st_reg.writeMask;
      OFS_CTRL_SEL_SET,
      OFS_CTRL_SEL_CLEAR,
      OFS_OUT_EN_SET,
      OFS_OUT_EN_CLEAR,
      OFS_FILTER_SET,
      OFS_FILTER_CLEAR,
      OFS_OUT_DATA_SET,
      OFS_OUT_DATA_CLEAR,
      OFS_IRQ_MASK_SET,
      OFS_IRQ_MASK_CLEAR,
      OFS_OPEN_DRAIN_SET,
      OFS_OPEN_DRAIN_CLEAR,
      OFS_PERIPH_A_SELECT,
      OFS_PERIPH_B_SELECT,
      OFS_WRITE_MASK_SET,
      OFS_WRITE_MASK_CLEAR:  rdMux = '0;
      default:               knownAddr = 1'b0;
    endcase
  end

  // only the bits actually returned by a status read are cleared
  assign rdClear = accessDone & ~pwrite & (paddr == OFS_IRQ_STATUS);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;

    // bus capture and completion
    if (setupPh && !st_reg.rdDone) begin
      st_next.rdData = rdMux;
      st_next.rdErr  = ~knownAddr;
      st_next.rdDone = 1'b1;
    end
    if (accessDone) begin
      st_next.rdDone = 1'b0;
      st_next.rdErr  = 1'b0;
    end

    // configuration writes, independent of the controller clock gate
    if (wrDone) begin
      unique case (paddr)
        OFS_CTRL_SEL_SET:     st_next.ctrlSel      = st_reg.ctrlSel | pwdata;
        OFS_CTRL_SEL_CLEAR:   st_next.ctrlSel      = st_reg.ctrlSel & ~pwdata;
        OFS_OUT_EN_SET:       st_next.outEn        = st_reg.outEn | pwdata;
        OFS_OUT_EN_CLEAR:     st_next.outEn        = st_reg.outEn & ~pwdata;
        OFS_FILTER_SET:       st_next.fltEn        = st_reg.fltEn | pwdata;
        OFS_FILTER_CLEAR:     st_next.fltEn        = st_reg.fltEn & ~pwdata;
        OFS_OUT_DATA_SET:     st_next.outData      = st_reg.outData | pwdata;
        OFS_OUT_DATA_CLEAR:   st_next.outData      = st_reg.outData & ~pwdata;
        OFS_OUT_DATA_VALUE:   st_next.outData      = (st_reg.outData & ~st_reg.writeMask)
                                                   | (pwdata & st_reg.writeMask);
        OFS_IRQ_MASK_SET:     st_next.irqMask      = st_reg.irqMask | pwdata;
        OFS_IRQ_MASK_CLEAR:   st_next.irqMask      = st_reg.irqMask & ~pwdata;
        OFS_OPEN_DRAIN_SET:   st_next.openDrain    = st_reg.openDrain | pwdata;
        OFS_OPEN_DRAIN_CLEAR: st_next.openDrain    = st_reg.openDrain & ~pwdata;
        OFS_PERIPH_A_SELECT:  st_next.periphChoice = st_reg.periphChoice & ~pwdata;
        OFS_PERIPH_B_SELECT:  st_next.periphChoice = st_reg.periphChoice | pwdata;
        OFS_WRITE_MASK_SET:   st_next.writeMask    = st_reg.writeMask | pwdata;
        OFS_WRITE_MASK_CLEAR: st_next.writeMask    = st_reg.writeMask & ~pwdata;
        default:              st_next.rdErr        = 1'b0;
      endcase
    end

    // registered pin drive: open drain lines never drive high
    st_next.pinOut = drvLevel & ~st_reg.openDrain;
    st_next.pinOeN = ~(drvOn & ~(st_reg.openDrain & drvLevel));

    // sampling stops with the controller clock, so readback holds
    if (ctrlClkOn) begin
      st_next.pinSmp  = pinIn;
      st_next.pinFlt  = st_reg.pinSmp;
      st_next.lvlPrev = levelNow;
    end

    // a change in the clearing cycle survives the clear
    st_next.irqStat = (st_reg.irqStat & ~(rdClear ? st_reg.rdData : '0)) | changed;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg              <= '0;
      st_reg.ctrlSel      <= RST_CTRL_SEL;
      st_reg.periphChoice <= RST_ZERO;
      st_reg.writeMask    <= RST_ZERO;
      st_reg.openDrain    <= RST_ZERO;
      st_reg.irqMask      <= RST_ZERO;
      st_reg.irqStat      <= RST_ZERO;
      st_reg.pinOeN       <= RST_PIN_OE_N;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  assign pinOut = st_reg.pinOut;
  assign pinOeN = st_reg.pinOeN;

endmodule
`default_nettype wire

// File: tb/gio_ctrl_props.sv
// Purpose: port checks for gio_ctrl
// Assumes: clkEn is high in every APB setup cycle
// Notes:   shadows the mask and open-drain writes seen on the bus
`timescale 1ns/1ps
`default_nettype none
module gio_ctrl_props
  import gio_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      rstn,
  input wire logic      clkEn,
  input wire logic      psel,
  input wire logic      penable,
  input wire logic      pwrite,
  input wire gio_addr_t paddr,
  input wire gio_word_t pwdata,
  input wire logic      pready,
  input wire gio_word_t prdata,
  input wire logic      pslverr,
  input wire gio_word_t pinIn,
  input wire gio_word_t pinOut,
  input wire gio_word_t pinOeN,
  input wire gio_word_t periphIn,
  input wire logic      changeIrq
);
  gio_word_t odReg, odDrv, mskReg;
  logic      setupQ, wrDone;
  assign wrDone = psel && penable && pready && pwrite;
  // pin drive lags a register write by one enabled edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      odReg  <= '0;
      odDrv  <= '0;
      mskReg <= '0;
      setupQ <= 1'b0;
    end else begin
      setupQ <= psel && !penable && clkEn;
      if (clkEn) odDrv <= odReg;
      if (wrDone && paddr == OFS_OPEN_DRAIN_SET) odReg <= odReg | pwdata;
      if (wrDone && paddr == OFS_OPEN_DRAIN_CLEAR) odReg <= odReg & ~pwdata;
      if (wrDone && paddr == OFS_IRQ_MASK_SET) mskReg <= mskReg | pwdata;
      if (wrDone && paddr == OFS_IRQ_MASK_CLEAR) mskReg <= mskReg & ~pwdata;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ready_setup_a: assert property (psel && !penable && clkEn |=> pready || !clkEn)
    else $error("pready missing after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  freeze_hold_a: assert property (!$past(clkEn) |-> $stable(pinOut) && $stable(pinOeN)
    && $stable(changeIrq)) else $error("state moved while frozen");
  raw_periph_a: assert property (periphIn == pinIn)
    else $error("peripheral input not raw pin");
  irq_mask_a: assert property (mskReg == '0 |-> !changeIrq)
    else $error("interrupt with mask clear");
  od_no_high_a: assert property ((odDrv & ~pinOeN & pinOut) == '0)
    else $error("open-drain line driven high");
  rdata_hold_a: assert property (!setupQ |-> $stable(prdata))
    else $error("prdata moved without setup");
endmodule
bind gio_ctrl gio_ctrl_props chk (.sys_clk, .rstn, .clkEn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prdata, .pslverr, .pinIn, .pinOut, .pinOeN, .periphIn, .changeIrq);
`default_nettype wire

// File: tb/gio_pins.sv
// Purpose: pins and outside world of the line controller
// Assumes: every line has a pull-up; outside drivers only pull low
// Notes:   levels are combinational, synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module gio_pins
  import gio_pkg::*;
(
  input  wire gio_word_t pinOut,
  input  wire gio_word_t pinOeN,
  input  wire gio_word_t extDrv,
  input  wire gio_word_t extLvl,
  output var gio_word_t  pinIn
);
  // released lines float up, so shared lines act as a wired-and
  assign pinIn = ~(~pinOeN & ~pinOut) & ~(extDrv & ~extLvl);
endmodule
`default_nettype wire

// File: tb/tb_gio_output_input_control.sv
// Purpose: self-checking bench for gio_ctrl
// Assumes: pins synchronous to sys_clk, pulled up
// Notes:   bench model keeps one word per set/clear/status triplet
`timescale 1ns/1ps
`default_nettype none
module tb_gio_output_input_control
  import gio_pkg::*;
;
  logic        sys_clk = 0, rstn = 0, clkEn = 1, ctrlClkOn = 1;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, changeIrq, e;
  gio_addr_t   paddr = '0, ca, st;
  gio_word_t   pwdata = '0, prdata, pinIn, pinOut, pinOeN, periphIn, q, r, old;
  gio_word_t   extDrv = '0, seed = 32'h62111FC8;
  gio_word_t   m[8];
  gio_periph_t periph = '0;
  int          fail_count = 0, total_checks = 0, cyc = 0;
  localparam gio_addr_t SA[8] = '{OFS_CTRL_SEL_SET, OFS_OUT_EN_SET, OFS_FILTER_SET,
    OFS_OUT_DATA_SET, OFS_IRQ_MASK_SET, OFS_OPEN_DRAIN_SET, OFS_WRITE_MASK_SET,
    OFS_PERIPH_B_SELECT};
  gio_ctrl dut (.sys_clk, .rstn, .clkEn, .ctrlClkOn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .pinIn, .pinOut, .pinOeN, .periph, .periphIn,
    .changeIrq);
  gio_pins pins (.pinOut, .pinOeN, .extDrv, .extLvl(32'h0), .pinIn);
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      results();
    end
  end
  function automatic gio_word_t rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic gio_word_t pinExp();
    gio_word_t drv, out;
    drv = m[0] & m[1] | ~m[0] & (m[7] & periph.drvB | ~m[7] & periph.drvA);
    out = m[0] & m[3] | ~m[0] & (m[7] & periph.outB | ~m[7] & periph.outA);
    return ~(drv & ~out) & ~extDrv;
  endfunction
  task automatic cmp(input gio_word_t got, input gio_word_t exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input gio_addr_t a, input gio_word_t d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input gio_addr_t a, input gio_word_t x);
    apb(0, a, rnd());
    cmp(q, x);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    foreach (m[i]) m[i] = RST_ZERO;
    m[0] = RST_CTRL_SEL;
    repeat (3) @(posedge sys_clk);
    rstn <= 1;
    for (int i = 0; i < 8; i++) begin
      ca = (i == 7) ? OFS_PERIPH_A_SELECT : SA[i] + 8'h04;
      st = (i == 7) ? OFS_PERIPH_CHOICE : SA[i] + 8'h08;
      rdc(st, m[i]);
      r = rnd();
      apb(1, SA[i], r);
      m[i] = m[i] | r;
      r = rnd();
      apb(1, ca, r);
      m[i] = m[i] & ~r;
      rdc(st, m[i]);
    end
    r = rnd();
    apb(1, OFS_OUT_DATA_VALUE, r);
    m[3] = m[3] & ~m[6] | r & m[6];
    rdc(OFS_OUT_DATA_VALUE, m[3]);
    apb(1, 8'h60, rnd());
    cmp(gio_word_t'(e), 32'h1);
    apb(1, OFS_CTRL_SEL_STATUS, ~m[0]);
    rdc(OFS_CTRL_SEL_STATUS, m[0]);
    rdc(OFS_OUT_EN_SET, 32'h0);
    apb(1, OFS_FILTER_CLEAR, 32'hFFFFFFFF);
    m[2] = '0;
    // freeze the block while the peripherals change their drive
    clkEn <= 0;
    periph <= {rnd(), rnd(), rnd(), rnd()};
    repeat (3) @(posedge sys_clk);
    clkEn <= 1;
    repeat (3) @(posedge sys_clk);
    cmp(pinIn, pinExp());
    rdc(OFS_PIN_LEVEL, pinExp());
    apb(1, OFS_CTRL_SEL_SET, 32'hFFFFFFFF);
    apb(1, OFS_OUT_EN_SET, 32'hFFFFFFFF);
    m[0] = '1;
    m[1] = '1;
    r = rnd();
    apb(1, OFS_OUT_DATA_CLEAR, r);
    m[3] = m[3] & ~r;
    @(posedge sys_clk);
    rdc(OFS_PIN_LEVEL, pinExp());
    apb(1, OFS_FILTER_SET, 32'hFFFFFFFF);
    m[2] = '1;
    repeat (3) @(posedge sys_clk);
    old = pinExp();
    apb(1, OFS_OUT_DATA_SET, r);
    m[3] = m[3] | r;
    @(posedge sys_clk);
    rdc(OFS_PIN_LEVEL, old);
    rdc(OFS_PIN_LEVEL, pinExp());
    old = pinExp();
    ctrlClkOn <= 0;
    extDrv <= rnd();
    repeat (3) @(posedge sys_clk);
    rdc(OFS_PIN_LEVEL, old);
    ctrlClkOn <= 1;
    repeat (4) @(posedge sys_clk);
    rdc(OFS_PIN_LEVEL, pinExp());
    apb(1, OFS_IRQ_MASK_CLEAR, 32'hFFFFFFFF);
    r = rnd();
    apb(1, OFS_IRQ_MASK_SET, r);
    apb(0, OFS_IRQ_STATUS, 32'h0);
    old = pinExp();
    extDrv <= rnd();
    repeat (5) @(posedge sys_clk);
    cmp(gio_word_t'(changeIrq), gio_word_t'(|((old ^ pinExp()) & r)));
    rdc(OFS_IRQ_STATUS, old ^ pinExp());
    rdc(OFS_IRQ_STATUS, 32'h0);
    cmp(gio_word_t'(changeIrq), 32'h0);
    results();
  end
endmodule
`default_nettype wire
